// >>> hw/io_strobe_pkg.sv
// Package of types and constants for the I/O strobe glue block
`default_nettype none
package io_strobe_pkg;
    // Processor bus clock rate
    localparam int unsigned BUS_CLK_HZ = 25_000_000;
    localparam int unsigned BUS_CLK_PERIOD_NS = 1_000_000_000 / BUS_CLK_HZ;

    // Width of the upper address field used for region decode
    localparam int unsigned REGION_BITS = 3;

    // Upper address codes of the transceiver regions
    localparam logic [2:0] REGION_UART = 3'h1;
    localparam logic [2:0] REGION_PARPORT = 3'h3;
    localparam logic [2:0] REGION_BOOTFLASH = 3'h7;

    // Reset value of the read strobe (inactive high)
    localparam logic READ_STROBE_RESET_N = 1'h1;

    // Read strobe states, one-hot
    typedef enum logic [1:0] {
        RD_IDLE = 2'b01,
        RD_ACTIVE = 2'b10
    } rd_state_t;

    // Processor local bus signals seen by the block, all on CLK
    typedef struct packed {
        logic address_strobe_n;
        logic last_transfer_n;
        logic write_not_read;
        logic wait_n;
        logic bus_data_enable_n;
        logic transfer_direction;
        logic [REGION_BITS-1:0] addr_hi;
    } cpu_bus_t;

    // Peripheral control outputs, all active low except direction
    typedef struct packed {
        logic read_strobe_n;
        logic io_write_n;
        logic dram_write_n;
        logic transfer_direction;
        logic transceiver_output_enable_n;
    } periph_ctl_t;
endpackage
`default_nettype wire

// >>> hw/io_strobe_glue.sv
// I/O strobe glue between the processor local bus and simple peripherals
//
// Summary of operation
// - Read strobe asserts on address strobe with read
// - Read strobe releases on last transfer
// - Reset holds read strobe inactive
// - Write strobe active on write during wait
// - DRAM write enable blocked during refresh
// - Direction select passes through unchanged
// - Transceiver enabled on data enable and region
// - Direction not gated by transceiver enable; processor turns it while disabled
// - Read strobe is the only registered output, updates on bus clock while CE is high
// - Refresh indication covers whole refresh cycle
// - Regions are UART, parallel port, boot flash
`default_nettype none
module io_strobe_glue
    import io_strobe_pkg::*;
(
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic CE,
    input wire io_strobe_pkg::cpu_bus_t CPU_BUS,
    input wire logic REFRESH_CYCLE_ACTIVE,
    output wire io_strobe_pkg::periph_ctl_t PERIPH_CTL
);
    import io_strobe_pkg::*;

    // Transceiver region table
    localparam int unsigned IO_REGION_COUNT = 3;

    // Codes of the upper address lines for each I/O region
    localparam logic [REGION_BITS-1:0] IO_REGION_CODE [IO_REGION_COUNT] = '{
        REGION_UART,
        REGION_PARPORT,
        REGION_BOOTFLASH
    };

    // Read strobe state
    rd_state_t rd_state_ff;

    rd_state_t nxt_rd_state;

    // Raw bus fields
    wire logic address_strobe_n;

    wire logic last_transfer_n;

    wire logic write_not_read;

    wire logic wait_n;

    wire logic bus_data_enable_n;

    wire logic transfer_direction;

    wire logic [REGION_BITS-1:0] region;

    // Active-high bus conditions
    wire logic addr_strobe;

    wire logic last_xfer;

    wire logic write_cyc;

    wire logic read_cyc;

    wire logic wait_act;

    wire logic data_en;

    // Region decode
    wire logic [IO_REGION_COUNT-1:0] region_hit;

    wire logic io_region;

    // Read strobe control
    wire logic read_start;

    wire logic read_end;

    wire logic state_step;

    wire logic strobe_idle;

    wire logic strobe_active;

    wire logic go_active;

    wire logic go_idle;

    // Combinational controls, active high
    wire logic io_write_act;

    wire logic dram_write_act;

    wire logic xcvr_enable_act;

    wire logic xcvr_direction;

    // Output word
    periph_ctl_t ctl_comb;

    // Unpack the bus
    assign address_strobe_n = CPU_BUS.address_strobe_n;

    assign last_transfer_n = CPU_BUS.last_transfer_n;

    assign write_not_read = CPU_BUS.write_not_read;

    assign wait_n = CPU_BUS.wait_n;

    assign bus_data_enable_n = CPU_BUS.bus_data_enable_n;

    assign transfer_direction = CPU_BUS.transfer_direction;

    assign region = CPU_BUS.addr_hi;

    // Bus conditions
    assign addr_strobe = ~address_strobe_n;

    assign last_xfer = ~last_transfer_n;

    assign write_cyc = write_not_read;

    assign read_cyc = ~write_not_read;

    assign wait_act = ~wait_n;

    assign data_en = ~bus_data_enable_n;

    // One comparator per transceiver region
    for (genvar g = 0; g < IO_REGION_COUNT; g++) begin : g_region
        assign region_hit[g] = (region == IO_REGION_CODE[g]);
    end

    assign io_region = |region_hit;

    // Read cycle start and end, no address qualification
    assign read_start = addr_strobe & read_cyc;

    assign read_end = last_xfer;

    // Clock enable gates every state update
    assign state_step = CE;

    // State decode
    assign strobe_idle = (rd_state_ff == RD_IDLE);

    assign strobe_active = (rd_state_ff == RD_ACTIVE);

    // Transitions; starts while active are ignored
    assign go_active = strobe_idle & read_start;

    assign go_idle = strobe_active & read_end;

    // Next state
    always_comb begin
        nxt_rd_state = rd_state_ff;

        case (rd_state_ff)
            RD_IDLE: begin
                if (go_active) begin
                    nxt_rd_state = RD_ACTIVE;
                end else begin
                    nxt_rd_state = RD_IDLE;
                end
            end

            RD_ACTIVE: begin
                if (go_idle) begin
                    nxt_rd_state = RD_IDLE;
                end else begin
                    nxt_rd_state = RD_ACTIVE;
                end
            end

            default: begin
                nxt_rd_state = RD_IDLE;
            end
        endcase
    end

    // State register; reset wins over a coinciding read start
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            rd_state_ff <= RD_IDLE;
        end else if (state_step) begin
            rd_state_ff <= nxt_rd_state;
        end
    end

    // Write strobe during the wait states of a write
    assign io_write_act = write_cyc & wait_act;

    // No DRAM write while a refresh cycle runs
    assign dram_write_act = write_cyc
        & ~REFRESH_CYCLE_ACTIVE;

    // Direction straight through; the processor turns it while disabled
    assign xcvr_direction = transfer_direction;

    // Transceiver only for the I/O regions, never for DRAM
    assign xcvr_enable_act = data_en & io_region;

    // Output word, active-low strobes
    always_comb begin
        ctl_comb = '1;

        ctl_comb.read_strobe_n = strobe_active ? 1'b0 : READ_STROBE_RESET_N;
        ctl_comb.io_write_n = ~io_write_act;
        ctl_comb.dram_write_n = ~dram_write_act;
        ctl_comb.transfer_direction = xcvr_direction;
        ctl_comb.transceiver_output_enable_n = ~xcvr_enable_act;
    end

    assign PERIPH_CTL = ctl_comb;

endmodule // io_strobe_glue
`default_nettype wire

// >>> verif/io_strobe_cpu_model.sv
// Processor bus model
`default_nettype none
module io_strobe_cpu_model (
    input wire logic clk,
    input wire logic [8:0] req,
    output var io_strobe_pkg::cpu_bus_t bus = '1
);
    always @(negedge clk) bus <= req;
endmodule // io_strobe_cpu_model
`default_nettype wire

// >>> verif/io_strobe_glue_asserts.sv
// Checker for the I/O strobe glue
`default_nettype none
module io_strobe_glue_asserts import io_strobe_pkg::*; (
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic CE,
    input wire io_strobe_pkg::cpu_bus_t CPU_BUS,
    input wire logic REFRESH_CYCLE_ACTIVE,
    input wire io_strobe_pkg::periph_ctl_t PERIPH_CTL
);
    wire cpu_bus_t b = CPU_BUS;
    wire rs = PERIPH_CTL.read_strobe_n;
    wire w = b.write_not_read;
    wire io = b.addr_hi inside {REGION_UART, REGION_PARPORT, REGION_BOOTFLASH};
    default clocking @(posedge CLK); endclocking
    default disable iff (!RSTN);
    sequence s_rd_start; CE && rs && !b.address_strobe_n && !w; endsequence
    property p_set; s_rd_start |=> !rs; endproperty
    a_set: assert property (p_set) else $error("read strobe missed");
    property p_idle; CE && rs && !(!b.address_strobe_n && !w) |=> rs; endproperty
    a_idle: assert property (p_idle) else $error("read strobe without read");
    property p_keep; CE && !rs && b.last_transfer_n |=> !rs; endproperty
    a_keep: assert property (p_keep) else $error("read strobe dropped");
    property p_hold; !CE |=> $stable(rs); endproperty
    a_hold: assert property (p_hold) else $error("strobe moved with enable low");
    property p_clr; CE && !rs && !b.last_transfer_n |=> rs; endproperty
    a_clr: assert property (p_clr) else $error("read strobe kept");
    property p_rst; disable iff (1'b0) !RSTN |-> rs; endproperty
    a_rst: assert property (p_rst) else $error("strobe in reset");
    property p_cmb; PERIPH_CTL[3:0] == {~(w & ~b.wait_n), ~(w & ~REFRESH_CYCLE_ACTIVE),
        b.transfer_direction, ~(~b.bus_data_enable_n & io)}; endproperty
    a_cmb: assert property (p_cmb) else $error("control wrong");
endmodule // io_strobe_glue_asserts
bind io_strobe_glue io_strobe_glue_asserts u_io_strobe_glue_asserts (.*);
`default_nettype wire

// >>> verif/io_strobe_glue_tb_top.sv
// Testbench for the I/O strobe glue
`default_nettype none
module io_strobe_glue_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic CLK = 0, RSTN = 1, rf = 0, ce = 1;
    logic [8:0] rq = 9'h1B0;
    io_strobe_pkg::cpu_bus_t bus;
    io_strobe_pkg::periph_ctl_t o;
    int err_count = 0, tests_run = 0, cyc = 0;
    io_strobe_cpu_model u_io_strobe_cpu_model (.clk(CLK), .req(rq), .bus(bus));
    io_strobe_glue u_io_strobe_glue (.CLK(CLK), .RSTN(RSTN), .CE(ce), .CPU_BUS(bus),
        .REFRESH_CYCLE_ACTIVE(rf), .PERIPH_CTL(o));
    initial forever #20 CLK = ~CLK;
    always @(posedge CLK) if (++cyc > 900) begin err_count++; end_of_test(); end
    task chk(input logic ok);
        tests_run++;
        if (ok !== 1'b1) begin err_count++; $display("[ERR] %0t bad output", $time); end
    endtask
    task go(input logic [8:0] v, input int n, input logic e);
        rq = v;
        repeat (n) @(posedge CLK);
        #1 chk(o.read_strobe_n === e);
    endtask
    task ce_test;
        rq = 9'h130;
        @(negedge CLK) ce = 0;
        @(posedge CLK);
        #1 chk(o.read_strobe_n === 1'b0);
        @(negedge CLK) ce = 1;
        @(posedge CLK);
        #1 chk(o.read_strobe_n === 1'b1);
        rq = 9'h0B0;
        @(negedge CLK) ce = 0;
        @(posedge CLK);
        #1 chk(o.read_strobe_n === 1'b1);
        @(negedge CLK) ce = 1;
        @(posedge CLK);
        #1 chk(o.read_strobe_n === 1'b0);
    endtask
    task comb_sweep;
        for (int i = 0; i < 256; i++) begin
            logic [3:0] exp_ctl;
            exp_ctl = {!(i[6] & !i[5]), !(i[6] & !i[7]), i[3] == 1,
                !(!i[4] && i[2:0] inside {1, 3, 7})};
            rq = {2'b11, i[6:0]};
            @(negedge CLK) rf = i[7];
            #1 chk(o[3:0] === exp_ctl);
        end
    endtask
    task end_of_test;
        $display("errors %0d checks %0d", err_count, tests_run);
        if (err_count == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        #5 RSTN = 0;
        repeat (3) @(posedge CLK);
        @(negedge CLK) RSTN = 1;
        @(posedge CLK);
        #1;
        go(9'h0B0, 1, 0);
        go(9'h1B0, 3, 0);
        go(9'h030, 1, 1);
        go(9'h0B0, 1, 0);
        go(9'h0F0, 2, 0);
        go(9'h130, 1, 1);
        go(9'h0F0, 2, 1);
        go(9'h0B0, 1, 0);
        ce_test();
        @(negedge CLK) RSTN = 0;
        go(9'h0B0, 1, 1);
        @(negedge CLK) RSTN = 1;
        comb_sweep();
        end_of_test();
    end
endmodule // io_strobe_glue_tb_top
`default_nettype wire
